//--- lhse_params.svh
// Register offsets, field positions, reset values and timing counts for the LIN header engine
`ifndef LHSE_PARAMS_SVH
`define LHSE_PARAMS_SVH
`define LHSE_CTRL_OFS 8'h00
`define LHSE_MODE_OFS 8'h04
`define LHSE_STAT_OFS 8'h08
`define LHSE_IDENT_OFS 8'h0c
`define LHSE_BAUD_OFS 8'h10
`define LHSE_CTRL_RESET_STATUS_COMMAND_BIT 0
`define LHSE_MODE_MASTER 4'ha
`define LHSE_MODE_SLAVE 4'hb
`define LHSE_MODE_RESET 4'h0
`define LHSE_BAUD_CD_RESET 16'h0008
`define LHSE_BAUD_FP_RESET 3'h0
`define LHSE_STAT_TRANSMITTER_READY_FLAG_BIT 0
`define LHSE_STAT_BRK_BIT 1
`define LHSE_STAT_ID_BIT 2
`define LHSE_STAT_ISFE_BIT 3
`define LHSE_SYNCH_CHAR 8'h55
`define LHSE_BRK_TX_BITS 5'd13
`define LHSE_BRK_RX_BITS 5'd11
`define LHSE_OVERSAMPLE 5'd16
`define LHSE_MEAS_BITS 4'd8
`endif

//--- lhse_pkg.sv
// Types shared by the LIN header engine
`default_nettype none
package lhse_pkg;
  typedef enum logic [3:0] {
    LHSE_IDLE, LHSE_TX_BRK, LHSE_TX_DEL, LHSE_TX_CHR,
    LHSE_RX_HUNT, LHSE_RX_WSTART, LHSE_RX_CHR, LHSE_RX_WIDLE
  } lhse_state_t;
endpackage : lhse_pkg
`default_nettype wire

//--- lhse_top.sv
// LIN header transmit, break detect, synch check and baud resync engine
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lhse_params.svh"
module lhse_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic lin_rx,
  output logic lin_tx
);
  // Register state
  logic ack_ff, tx_ff, rdy_ff, brk_ff, idd_ff, isfe_ff;
  logic [31:0] dat_ff;
  logic [3:0] mode_ff;
  logic [7:0] ident_ff;
  logic [15:0] cd_ff;
  logic [2:0] fp_ff;
  lhse_pkg::lhse_state_t st_ff;
  logic [1:0] fld_ff;
  logic [3:0] bit_ff, smp_ff, meas_bits_ff;
  // Dominant run in sample ticks, measurement prescaler
  logic [7:0] run_ff;
  logic [3:0] pre_ff;
  logic [15:0] tick_cnt_ff;
  logic [2:0] frac_ff;
  logic [9:0] shf_ff;
  logic [7:0] rxsh_ff;
  logic [18:0] meas_ff;
  logic meas_on_ff;
  logic rx_s1_ff, rx_s2_ff, rx_d_ff;

  // Bus decode
  wire acc = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr & (wb_adr_i == `LHSE_CTRL_OFS);
  wire wr_mode = wr & (wb_adr_i == `LHSE_MODE_OFS);
  wire wr_ident = wr & (wb_adr_i == `LHSE_IDENT_OFS);
  wire wr_baud = wr & (wb_adr_i == `LHSE_BAUD_OFS) & (&wb_sel_i[2:0]);
  wire reset_status_command = wr_ctrl & wb_dat_i[`LHSE_CTRL_RESET_STATUS_COMMAND_BIT];
  wire is_master = (mode_ff == `LHSE_MODE_MASTER);
  wire is_slave = (mode_ff == `LHSE_MODE_SLAVE);
  wire [31:0] stat_w = {28'h0, isfe_ff, idd_ff, brk_ff, rdy_ff};
  wire [31:0] rd_w = (wb_adr_i == `LHSE_MODE_OFS) ? {28'h0, mode_ff} :
                     (wb_adr_i == `LHSE_STAT_OFS) ? stat_w :
                     (wb_adr_i == `LHSE_IDENT_OFS) ? {24'h0, ident_ff} :
                     (wb_adr_i == `LHSE_BAUD_OFS) ? {13'h0, fp_ff, cd_ff} : 32'h0;

  // Sample tick: divider cd plus fp/8 fraction, sixteen ticks per bit
  wire [3:0] frac_sum = {1'b0, frac_ff} + {1'b0, fp_ff};
  wire [15:0] tick_top = frac_sum[3] ? cd_ff : cd_ff - 16'h1;
  wire tick = (tick_cnt_ff >= tick_top);
  wire bit_end = tick & (smp_ff == 4'hf);
  wire rx = rx_s2_ff;
  wire rx_fall = rx_d_ff & ~rx;

  // Master start: identifier write while ready
  wire tx_start = wr_ident & is_master & rdy_ff & (st_ff == lhse_pkg::LHSE_IDLE);
  wire rx_done = (st_ff == lhse_pkg::LHSE_RX_CHR) & bit_end & (bit_ff == 4'd9);
  wire tx_chr_done = (st_ff == lhse_pkg::LHSE_TX_CHR) & bit_end & (bit_ff == 4'd9);
  wire [7:0] brk_ticks = {3'h0, `LHSE_BRK_RX_BITS} * {3'h0, `LHSE_OVERSAMPLE} - 8'd1;
  wire brk_seen = is_slave & tick & ~rx & (run_ff == brk_ticks);
  wire brk_sent = (st_ff == lhse_pkg::LHSE_TX_DEL) & bit_end;
  wire id_sent = tx_chr_done & (fld_ff == 2'd1);
  wire synch_rx = rx_done & (fld_ff == 2'd0) & is_slave;
  wire id_rx = rx_done & (fld_ff == 2'd1) & is_slave;
  wire synch_bad = synch_rx & (rxsh_ff != `LHSE_SYNCH_CHAR);
  // Synch falling edges come every two bits; the fourth after the start ends eight bits
  wire meas_start = is_slave & (st_ff == lhse_pkg::LHSE_RX_WSTART) & ~rx & (fld_ff == 2'd0);
  wire meas_end = meas_on_ff & rx_fall & (meas_bits_ff == (`LHSE_MEAS_BITS >> 1) - 4'd1);
  wire [7:0] id_char = {ident_ff[7:6], ident_ff[5:0]};

  // Bus slave registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
      mode_ff <= `LHSE_MODE_RESET;
    end else begin
      ack_ff <= acc;
      if (acc) dat_ff <= rd_w;
      if (wr_mode) mode_ff <= wb_dat_i[3:0];
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign lin_tx = tx_ff;

  // Sticky flags, set wins over reset-status; ready drops on header start and returns in the identifier
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brk_ff <= 1'b0;
      idd_ff <= 1'b0;
      isfe_ff <= 1'b0;
      rdy_ff <= 1'b1;
    end else begin
      brk_ff <= brk_sent | brk_seen | (brk_ff & ~reset_status_command);
      idd_ff <= id_sent | id_rx | (idd_ff & ~reset_status_command);
      isfe_ff <= synch_bad | (isfe_ff & ~reset_status_command);
      if (tx_start) rdy_ff <= 1'b0;
      else if ((st_ff == lhse_pkg::LHSE_TX_CHR) & (fld_ff == 2'd1) & (bit_ff == 4'd0) & tick)
        rdy_ff <= 1'b1;
    end
  end

  // Identifier and baud registers, resync on slave synch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ident_ff <= 8'h0;
      cd_ff <= `LHSE_BAUD_CD_RESET;
      fp_ff <= `LHSE_BAUD_FP_RESET;
    end else begin
      if (id_rx) ident_ff <= rxsh_ff;
      else if (wr_ident & rdy_ff) ident_ff <= wb_dat_i[7:0];
      // A bad or unfinished synch measurement leaves the divider alone
      if (synch_rx & is_slave & ~synch_bad & ~meas_on_ff & (meas_ff[18:3] != 16'h0)) begin
        cd_ff <= meas_ff[18:3];
        fp_ff <= meas_ff[2:0];
      end else if (wr_baud) begin
        cd_ff <= wb_dat_i[15:0];
        fp_ff <= wb_dat_i[18:16];
      end
    end
  end

  // Rx synchroniser, tick divider, dominant run counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_d_ff <= 1'b1;
      tick_cnt_ff <= 16'h0;
      frac_ff <= 3'h0;
      run_ff <= 8'h0;
    end else begin
      rx_s1_ff <= lin_rx;
      rx_s2_ff <= rx_s1_ff;
      rx_d_ff <= rx_s2_ff;
      tick_cnt_ff <= tick ? 16'h0 : tick_cnt_ff + 16'h1;
      if (tick) frac_ff <= frac_sum[2:0];
      if (rx) run_ff <= 8'h0;
      else if (tick & (run_ff != 8'hff)) run_ff <= run_ff + 8'h1;
    end
  end

  // Synch measurement: one count per sixteen clocks, so count/8 is clocks per sample tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meas_ff <= 19'h0;
      meas_on_ff <= 1'b0;
      meas_bits_ff <= 4'h0;
      pre_ff <= 4'h0;
    end else if (meas_start) begin
      meas_ff <= 19'h0;
      meas_on_ff <= 1'b1;
      meas_bits_ff <= 4'h0;
      pre_ff <= 4'h8; // Half a count, rounds to nearest
    end else if (meas_on_ff) begin
      pre_ff <= pre_ff + 4'h1;
      if (pre_ff == 4'hf) meas_ff <= meas_ff + 19'h1;
      if (rx_fall) meas_bits_ff <= meas_bits_ff + 4'h1;
      if (meas_end) meas_on_ff <= 1'b0;
    end
  end

  // Header state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= lhse_pkg::LHSE_IDLE;
      fld_ff <= 2'd0;
      bit_ff <= 4'h0;
      smp_ff <= 4'h0;
      shf_ff <= 10'h3ff;
      rxsh_ff <= 8'h0;
      tx_ff <= 1'b1;
    end else begin
      if (tick) smp_ff <= smp_ff + 4'h1;
      if (brk_seen) begin
        st_ff <= lhse_pkg::LHSE_RX_WIDLE;
        fld_ff <= 2'd0;
      end else begin
        case (st_ff)
          lhse_pkg::LHSE_IDLE: begin
            tx_ff <= 1'b1;
            if (tx_start) begin
              st_ff <= lhse_pkg::LHSE_TX_BRK;
              bit_ff <= 4'h0;
              smp_ff <= 4'h0;
              tx_ff <= 1'b0;
            end
            // slave stays here, discarding data, until a break
          end
          lhse_pkg::LHSE_TX_BRK: if (bit_end) begin
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == `LHSE_BRK_TX_BITS - 5'd1) begin
              st_ff <= lhse_pkg::LHSE_TX_DEL;
              tx_ff <= 1'b1;
            end
          end
          lhse_pkg::LHSE_TX_DEL: if (bit_end) begin
            st_ff <= lhse_pkg::LHSE_TX_CHR;
            fld_ff <= 2'd0;
            bit_ff <= 4'h0;
            shf_ff <= {1'b1, `LHSE_SYNCH_CHAR, 1'b0};
            tx_ff <= 1'b0;
          end
          lhse_pkg::LHSE_TX_CHR: if (bit_end) begin
            if (bit_ff == 4'd9) begin
              bit_ff <= 4'h0;
              if (fld_ff == 2'd0) begin
                fld_ff <= 2'd1;
                shf_ff <= {1'b1, id_char, 1'b0};
                tx_ff <= 1'b0;
              end else begin
                st_ff <= lhse_pkg::LHSE_IDLE;
                tx_ff <= 1'b1;
              end
            end else begin
              bit_ff <= bit_ff + 4'h1;
              tx_ff <= shf_ff[bit_ff + 4'h1];
            end
          end
          lhse_pkg::LHSE_RX_WIDLE: if (rx) st_ff <= lhse_pkg::LHSE_RX_WSTART;
          lhse_pkg::LHSE_RX_WSTART: if (~rx) begin
            st_ff <= lhse_pkg::LHSE_RX_CHR;
            bit_ff <= 4'h0;
            smp_ff <= 4'h8; // Centre sampling
          end
          lhse_pkg::LHSE_RX_CHR: if (bit_end) begin
            if ((bit_ff >= 4'd1) & (bit_ff <= 4'd8)) rxsh_ff <= {rx, rxsh_ff[7:1]};
            if (bit_ff == 4'd9) begin
              if (fld_ff == 2'd0) begin
                fld_ff <= 2'd1;
                st_ff <= lhse_pkg::LHSE_RX_WSTART;
              end else st_ff <= lhse_pkg::LHSE_IDLE;
            end else bit_ff <= bit_ff + 4'h1;
          end
          default: st_ff <= lhse_pkg::LHSE_IDLE;
        endcase
      end
    end
  end

  // Checks
  ready_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_start |=> !rdy_ff) else $error("ready not dropped on header start");
  flags_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_status_command & !brk_sent & !brk_seen) |=> !brk_ff) else $error("break flag not cleared");
  flag_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    (idd_ff & !reset_status_command) |=> idd_ff) else $error("identifier flag lost");
  synch_err_a: assert property (@(posedge clk) disable iff (!reset_n)
    synch_bad |=> isfe_ff) else $error("synch error not flagged");
  id_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    id_rx |=> (ident_ff == $past(rxsh_ff)) && idd_ff) else $error("identifier not loaded");
  no_resync_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!is_slave && !wr_baud) |=> $stable(cd_ff)) else $error("master changed divider");
  brk_dominant_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == lhse_pkg::LHSE_TX_BRK) |-> !tx_ff) else $error("break not dominant");
  brk_detect_a: assert property (@(posedge clk) disable iff (!reset_n)
    brk_seen |=> brk_ff && (st_ff == lhse_pkg::LHSE_RX_WIDLE)) else $error("break missed");
  ready_back_a: assert property (@(posedge clk) disable iff (!reset_n)
    id_sent |-> rdy_ff) else $error("ready not back after identifier");
  brk_done_a: assert property (@(posedge clk) disable iff (!reset_n)
    brk_sent |=> brk_ff) else $error("break done flag not set");
  id_done_a: assert property (@(posedge clk) disable iff (!reset_n)
    id_sent |=> idd_ff) else $error("identifier done flag not set");
  hdr_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == lhse_pkg::LHSE_TX_DEL && bit_end && !brk_seen) |=>
    (st_ff == lhse_pkg::LHSE_TX_CHR && fld_ff == 2'd0 && !tx_ff))
    else $error("synch field not after break");
  resync_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    (synch_rx && !synch_bad && !meas_on_ff && (meas_ff[18:3] != 16'h0)) |=>
    ({cd_ff, fp_ff} == $past(meas_ff))) else $error("measured divider not loaded");
  meas_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!meas_on_ff && !meas_start) |=> $stable(meas_ff)) else $error("measurement not halted");
  slave_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    (is_slave && st_ff == lhse_pkg::LHSE_IDLE && !brk_seen) |=> (st_ff == lhse_pkg::LHSE_IDLE))
    else $error("slave left idle without break");
endmodule : lhse_top
`default_nettype wire

//--- lhse_lin_node.sv
// Far-side LIN node model that sends headers onto the bus
`timescale 1ns/1ps
`default_nettype none
module lhse_lin_node (
  output logic node_tx,
  input wire logic clk
);
  // Released line reads recessive through the bus pull-up
  initial node_tx = 1'b1;

  // Hold one level for a number of clocks
  task automatic drive(input logic v, input int clks);
    node_tx <= v;
    repeat (clks) @(posedge clk);
  endtask : drive

  // Start bit, eight data bits LSB first, stop bit
  task automatic send_char(input logic [7:0] c, input int bclk);
    @(posedge clk);
    drive(1'b0, bclk);
    for (int i = 0; i < 8; i++) begin
      drive(c[i], bclk);
    end
    drive(1'b1, bclk);
  endtask : send_char

  // Break, delimiter, synch and identifier back to back
  task automatic send_header(input int brk, input logic [7:0] syn, input logic [7:0] id,
                             input int bclk);
    @(posedge clk);
    drive(1'b0, brk * bclk);
    drive(1'b1, bclk);
    send_char(syn, bclk);
    send_char(id, bclk);
  endtask : send_header
endmodule : lhse_lin_node
`default_nettype wire

//--- test_lin_header_sync_engine.sv
// Self-checking bench for the LIN header engine
`timescale 1ns/1ps
`default_nettype none
module test_lin_header_sync_engine;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, lin_tx, node_tx;
  logic [33:0] hdr;
  wire lin_rx;
  int failures = 0;
  int samples_checked = 0;

  // Wired-AND bus, recessive high
  assign lin_rx = lin_tx & node_tx;
  initial forever #25 clk = ~clk;

  lhse_top u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lin_rx(lin_rx), .lin_tx(lin_tx));
  lhse_lin_node u_node (.node_tx(node_tx), .clk(clk));

  // Compare and count
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      failures++;
    end
  endtask : check

  // Closing report
  task print_verdict;
    $display("Checks made %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // Classic Wishbone single cycle, read data lands in q
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      failures++;
      print_verdict();
    end
  endtask : wb

  // Read status until all mask bits are set, bounded
  task poll(input logic [31:0] mask);
    int n;
    n = 0;
    q = 32'h0;
    while ((q & mask) !== mask && n < 400) begin
      repeat (50) @(posedge clk);
      wb(1'b0, 8'h08, 32'h0);
      n++;
    end
    if (n >= 400) begin
      failures++;
      print_verdict();
    end
  endtask : poll

  // Main sequence: reset values, master header, slave headers
  initial begin
    int n;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, 8'h08, 32'h0); check("status", q, 32'h1);
    wb(1'b0, 8'h10, 32'h0); check("baud", q, 32'h8);
    wb(1'b0, 8'h14, 32'h0); check("unmapped", q, 32'h0);
    wb(1'b1, 8'h04, 32'ha);
    wb(1'b0, 8'h04, 32'h0); check("mode", q, 32'ha);
    wb(1'b1, 8'h0c, 32'h3c);
    wb(1'b0, 8'h08, 32'h0); check("ready", q[0], 32'h0);
    wb(1'b1, 8'h0c, 32'h11);
    hdr = {1'b1, 8'h3c, 1'b0, 1'b1, 8'h55, 1'b0, 1'b1, 13'h0};
    n = 0;
    while (lin_tx !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      print_verdict();
    end
    // Sample each bit in its middle, 128 clocks per bit
    repeat (64) @(posedge clk);
    for (int i = 0; i < 34; i++) begin
      check("lin_tx", lin_tx, hdr[i]);
      repeat (128) @(posedge clk);
    end
    poll(32'h4);
    check("status", q, 32'h7);
    wb(1'b0, 8'h0c, 32'h0); check("ident", q, 32'h3c);
    wb(1'b0, 8'h10, 32'h0); check("baud", q, 32'h8);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h08, 32'h0); check("status", q, 32'h1);
    // Slave: short dominant run, then a header at a slower rate
    wb(1'b1, 8'h04, 32'hb);
    u_node.send_char(8'h00, 128);
    wb(1'b0, 8'h08, 32'h0); check("status", q & 32'he, 32'h0);
    u_node.send_header(13, 8'h55, 8'h2a, 132);
    poll(32'h4);
    check("status", q & 32'he, 32'h6);
    wb(1'b0, 8'h10, 32'h0); check("baud", q, 32'h20008);
    wb(1'b0, 8'h0c, 32'h0); check("ident", q, 32'h2a);
    // Bad synch character raises the sticky error
    wb(1'b1, 8'h00, 32'h1);
    u_node.send_header(13, 8'h54, 8'h15, 132);
    poll(32'h4);
    check("status", q & 32'he, 32'he);
    wb(1'b0, 8'h10, 32'h0); check("baud", q, 32'h20008);
    wb(1'b0, 8'h0c, 32'h0); check("ident", q, 32'h15);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h08, 32'h0); check("status", q, 32'h1);
    print_verdict();
  end
endmodule : test_lin_header_sync_engine
`default_nettype wire
